// ### rtl/watchdog_timer_pkg.sv
/*
 Constants for the watchdog timer unit: register byte addresses, control
 field positions, reset values, prescaler codes and timing figures.
 Assumes a 32-bit register port and a 32.768 kHz low-power oscillator.
*/
package watchdog_timer_pkg;

    // Register port widths.
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] RELOAD_ADDR  = 32'hffff0360;
    localparam logic [ADDR_W-1:0] COUNT_ADDR   = 32'hffff0364;
    localparam logic [ADDR_W-1:0] CONTROL_ADDR = 32'hffff0368;
    localparam logic [ADDR_W-1:0] CLEAR_ADDR   = 32'hffff036c;

    // Reset values.
    localparam logic [CNT_W-1:0] RELOAD_RST  = 16'h0040;
    localparam logic [CNT_W-1:0] COUNT_RST   = 16'h0040;
    localparam logic [CNT_W-1:0] CONTROL_RST = 16'h0000;

    // Control register field positions.
    localparam int CTRL_UP_BIT       = 8;
    localparam int CTRL_EN_BIT       = 7;
    localparam int CTRL_PERIODIC_BIT = 6;
    localparam int CTRL_WDT_BIT      = 5;
    localparam int CTRL_PRE_HI       = 3;
    localparam int CTRL_PRE_LO       = 2;
    localparam int CTRL_IRQ_SEL_BIT  = 1;
    localparam int CTRL_PD_STOP_BIT  = 0;

    // Writable control bits; bits 15 to 9 and 4 are reserved and read as zero.
    localparam logic [CNT_W-1:0] CTRL_MASK = 16'h01ef;

    // Prescaler select codes and the last prescaler count for divide-by-16 and divide-by-256.
    localparam logic [1:0] PRE_DIV1   = 2'h0;
    localparam logic [1:0] PRE_DIV16  = 2'h1;
    localparam logic [1:0] PRE_DIV256 = 2'h2;
    localparam int         PRE_W      = 8;
    localparam logic [PRE_W-1:0] PRE_LAST16  = 8'h0f;
    localparam logic [PRE_W-1:0] PRE_LAST256 = 8'hff;

    // Counter end points.
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;

    // Timing figures.
    localparam int LP_OSC_HZ         = 32768;
    localparam int MCLK_HZ           = 100_000_000;
    localparam int WDT_MAX_TIMEOUT_S = ((2 ** CNT_W) * 256) / LP_OSC_HZ;

endpackage

// ### rtl/watchdog_timer_unit.sv
/*
 Watchdog timer unit: a 16-bit reload timer that serves either as a general
 timer with a sticky interrupt or as a locked watchdog that resets the core or, with control bit one set, raises the interrupt.
 Assumes a register master on mclk_i, a free-running low-power oscillator
 pin, a debug-halt level from another domain and a power-down level on mclk_i.
*/
// Implementation choice: the address-and-strobe port.
// Function
// RULE1 - Two modes: normal timer and watchdog
// RULE2 - Overflow reloads count from reload register (a non-periodic normal-mode timer wraps to the opposite end point instead)
// RULE3 - Clocked by 32.768 kHz, divide 1/16/256
// RULE4 - Normal mode acts as 16-bit general timer
// RULE5 - Control bit five enters watchdog mode
// RULE6 - Watchdog counts down from reload to zero
// RULE7 - Longest timeout is 512 seconds
// RULE8 - Software avoids timeouts shorter than 30 ms
// RULE9 - Zero count gives reset or interrupt
// RULE10 - Clear write reloads, starting new timeout
// RULE11 - Watchdog mode locks reload and control
// RULE12 - Non power-on resets keep watchdog running
// RULE13 - Software configures watchdog at startup
// RULE14 - Counter pauses while debugger holds core
// RULE15 - Bit zero stops counting in power-down
// RULE16 - Normal mode clear write drops interrupt
// RULE17 - Reload and count are 16-bit, count read-only
// RULE18 - Control bits 3:2 pick prescaler
// RULE19 - Bit one picks interrupt instead of reset
// RULE20 - Bits 8,7,6: direction, enable, periodic
// RULE21 - Normal interrupt stays until clear write
`timescale 1ns/1ps

module watchdog_timer_unit #(
    parameter int CNT_WIDTH = watchdog_timer_pkg::CNT_W
) (
    // Clock and resets.
    input  wire logic                                 mclk_i,
    input  wire logic                                 sys_rst_i,
    input  wire logic                                 core_rst_i,
    // Register port.
    input  wire logic [watchdog_timer_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [watchdog_timer_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                                 reg_wr_i,
    input  wire logic                                 reg_rd_i,
    output logic      [watchdog_timer_pkg::DATA_W-1:0] reg_rdata_o,
    // Timing source and system levels.
    input  wire logic                                 lp_osc_i,
    input  wire logic                                 debug_halt_i,
    input  wire logic                                 periph_powerdown_i,
    // Events out.
    output logic                                      timer_irq_o,
    output logic                                      wdt_core_reset_o
);
    import watchdog_timer_pkg::*;

    // Control register fields.
    logic                 ctrl_up_reg;
    logic                 ctrl_en_reg;
    logic                 ctrl_periodic_reg;
    logic                 wdt_mode_reg;
    logic [1:0]           ctrl_pre_reg;
    logic                 ctrl_irq_sel_reg;
    logic                 stop_in_powerdown_reg;

    // Counter state.
    logic [CNT_WIDTH-1:0] reload_reg;
    logic [CNT_WIDTH-1:0] count_reg;
    logic [CNT_WIDTH-1:0] count_next;
    logic [PRE_W-1:0]     pre_cnt_reg;
    logic                 irq_reg;
    logic                 core_reset_reg;
    logic [DATA_W-1:0]    rdata_reg;

    // Synchronisers and edge detection.
    logic                 osc_meta_reg;
    logic                 osc_sync_reg;
    logic                 osc_prev_reg;
    logic                 dbg_meta_reg;
    logic                 dbg_sync_reg;

    // Decoded strobes and qualifiers.
    logic                 wr_reload;
    logic                 wr_control;
    logic                 wr_clear;
    logic                 osc_rise;
    logic                 running;
    logic                 frozen;
    logic                 pre_wrap;
    logic                 count_tick;
    logic                 terminal;
    logic                 wdt_expire;
    logic                 soft_reset;
    logic [CNT_WIDTH-1:0] ctrl_read;

    // Write decode; one helper keeps all address compares alike.
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] target);
        addr_hit = (addr == target);
    endfunction

    // True on the last prescaler count for the selected division.
    function automatic logic pre_is_last(input logic [1:0]       sel,
                                         input logic [PRE_W-1:0] cnt);
        logic last;
        last = 1'b0;
        unique case (sel)
            PRE_DIV1:   last = 1'b1;
            PRE_DIV16:  last = (cnt[3:0] == PRE_LAST16[3:0]);
            PRE_DIV256: last = (cnt == PRE_LAST256);
            default:    last = 1'b0;
        endcase
        pre_is_last = last;
    endfunction

    // The reload and control registers take no writes once watchdog mode is on.
    assign wr_reload  = reg_wr_i & addr_hit(reg_addr_i, RELOAD_ADDR) & ~wdt_mode_reg;  // RULE11
    assign wr_control = reg_wr_i & addr_hit(reg_addr_i, CONTROL_ADDR) & ~wdt_mode_reg; // RULE11
    assign wr_clear   = reg_wr_i & addr_hit(reg_addr_i, CLEAR_ADDR);

    // A core reset only touches the timer while it is not a watchdog.
    assign soft_reset = core_rst_i & ~wdt_mode_reg; // RULE12

    // The oscillator pin is asynchronous, so it is synchronised before use.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_meta_reg <= lp_osc_i;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    // The debug halt comes from the debug port domain.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            dbg_meta_reg <= 1'b0;
            dbg_sync_reg <= 1'b0;
        end else begin
            dbg_meta_reg <= debug_halt_i;
            dbg_sync_reg <= dbg_meta_reg;
        end
    end

    // Only low-power oscillator edges advance the timer.
    assign osc_rise = osc_sync_reg & ~osc_prev_reg; // RULE3

    // Watchdog mode runs on its own; normal mode follows the enable bit.
    assign running = wdt_mode_reg | ctrl_en_reg; // RULE1 RULE20

    // Debug access and an optional power-down stop hold both counters.
    assign frozen = dbg_sync_reg                                 // RULE14
                  | (stop_in_powerdown_reg & periph_powerdown_i); // RULE15

    assign pre_wrap   = pre_is_last(ctrl_pre_reg, pre_cnt_reg); // RULE18
    assign count_tick = osc_rise & running & ~frozen & pre_wrap;

    // Down counting ends at zero, up counting at full scale.
    assign terminal = (wdt_mode_reg | ~ctrl_up_reg) ? (count_reg == CNT_ZERO) // RULE6
                                                    : (count_reg == CNT_FULL);

    assign wdt_expire = count_tick & terminal & wdt_mode_reg; // RULE9

    // Prescaler: a reserved select never wraps, so the count stands still.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || soft_reset || wr_control) begin
            pre_cnt_reg <= '0;
        end else if (osc_rise && running && !frozen) begin
            pre_cnt_reg <= pre_wrap ? '0 : pre_cnt_reg + 1'b1; // RULE3 RULE18
        end
    end

    // Control fields; only a power-on reset can leave watchdog mode.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || soft_reset) begin
            ctrl_up_reg           <= CONTROL_RST[CTRL_UP_BIT];
            ctrl_en_reg           <= CONTROL_RST[CTRL_EN_BIT];
            ctrl_periodic_reg     <= CONTROL_RST[CTRL_PERIODIC_BIT];
            wdt_mode_reg          <= CONTROL_RST[CTRL_WDT_BIT];
            ctrl_pre_reg          <= CONTROL_RST[CTRL_PRE_HI:CTRL_PRE_LO];
            ctrl_irq_sel_reg      <= CONTROL_RST[CTRL_IRQ_SEL_BIT];
            stop_in_powerdown_reg <= CONTROL_RST[CTRL_PD_STOP_BIT];
        end else if (wr_control) begin
            ctrl_up_reg           <= reg_wdata_i[CTRL_UP_BIT];        // RULE20
            ctrl_en_reg           <= reg_wdata_i[CTRL_EN_BIT];        // RULE20
            ctrl_periodic_reg     <= reg_wdata_i[CTRL_PERIODIC_BIT];  // RULE20
            wdt_mode_reg          <= reg_wdata_i[CTRL_WDT_BIT];       // RULE5
            ctrl_pre_reg          <= reg_wdata_i[CTRL_PRE_HI:CTRL_PRE_LO];
            ctrl_irq_sel_reg      <= reg_wdata_i[CTRL_IRQ_SEL_BIT];   // RULE19
            stop_in_powerdown_reg <= reg_wdata_i[CTRL_PD_STOP_BIT];   // RULE15
        end
    end

    // Reload value.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || soft_reset) begin
            reload_reg <= RELOAD_RST;
        end else if (wr_reload) begin
            reload_reg <= reg_wdata_i[CNT_WIDTH-1:0]; // RULE17
        end
    end

    // Next count after a tick. In periodic mode an overflow reloads; a
    // free-running timer wraps through the opposite end point instead.
    always_comb begin
        count_next = count_reg;
        if (wdt_mode_reg) begin
            count_next = terminal ? reload_reg : count_reg - 1'b1; // RULE6 RULE2
        end else if (terminal) begin
            if (ctrl_periodic_reg) begin
                count_next = reload_reg; // RULE2 RULE4
            end else begin
                count_next = ctrl_up_reg ? CNT_ZERO : CNT_FULL; // RULE4
            end
        end else begin
            count_next = ctrl_up_reg ? count_reg + 1'b1 : count_reg - 1'b1; // RULE20
        end
    end

    // Count register. A refresh in watchdog mode restarts the timeout, and
    // entering watchdog mode starts the first timeout from the reload value.
    // A full-scale reload at divide-by-256 lasts 65536 x 256 oscillator
    // periods, the longest timeout the unit can give.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || soft_reset) begin
            count_reg <= COUNT_RST;
        end else if (wr_clear && wdt_mode_reg) begin
            count_reg <= reload_reg; // RULE10
        end else if (wr_reload) begin
            count_reg <= reg_wdata_i[CNT_WIDTH-1:0];
        end else if (wr_control && reg_wdata_i[CTRL_WDT_BIT]) begin
            count_reg <= reload_reg; // RULE5 RULE7
        end else if (count_tick) begin
            count_reg <= count_next;
        end
    end

    // Sticky interrupt: a terminal count in normal mode, or an expiry with
    // the interrupt option in watchdog mode. A clear write drops it, but an
    // event in the same cycle wins so that it is never lost.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || soft_reset) begin
            irq_reg <= 1'b0;
        end else if (count_tick && terminal && (!wdt_mode_reg || ctrl_irq_sel_reg)) begin
            irq_reg <= 1'b1; // RULE9 RULE19 RULE21
        end else if (wr_clear) begin
            irq_reg <= 1'b0; // RULE16 RULE21
        end
    end

    // Expiry without the interrupt option pulses the core reset for one
    // cycle. The core reset it causes does not disturb the watchdog.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            core_reset_reg <= 1'b0;
        end else begin
            core_reset_reg <= wdt_expire & ~ctrl_irq_sel_reg; // RULE9 RULE19
        end
    end

    // Control readback with reserved bits as zero.
    always_comb begin
        ctrl_read                    = '0;
        ctrl_read[CTRL_UP_BIT]       = ctrl_up_reg;
        ctrl_read[CTRL_EN_BIT]       = ctrl_en_reg;
        ctrl_read[CTRL_PERIODIC_BIT] = ctrl_periodic_reg;
        ctrl_read[CTRL_WDT_BIT]      = wdt_mode_reg;
        ctrl_read[CTRL_PRE_HI:CTRL_PRE_LO] = ctrl_pre_reg;
        ctrl_read[CTRL_IRQ_SEL_BIT]  = ctrl_irq_sel_reg;
        ctrl_read[CTRL_PD_STOP_BIT]  = stop_in_powerdown_reg;
    end

    // Read data stand for exactly one cycle after the strobe. The clear
    // register and unmapped addresses read as zero.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || core_rst_i) begin
            rdata_reg <= '0;
        end else if (reg_rd_i) begin
            rdata_reg <= '0;
            if (addr_hit(reg_addr_i, RELOAD_ADDR)) begin
                rdata_reg[CNT_WIDTH-1:0] <= reload_reg;
            end else if (addr_hit(reg_addr_i, COUNT_ADDR)) begin
                rdata_reg[CNT_WIDTH-1:0] <= count_reg; // RULE17
            end else if (addr_hit(reg_addr_i, CONTROL_ADDR)) begin
                rdata_reg[CNT_WIDTH-1:0] <= ctrl_read & CTRL_MASK[CNT_WIDTH-1:0];
            end
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata_o      = rdata_reg;
    assign timer_irq_o      = irq_reg;
    assign wdt_core_reset_o = core_reset_reg;

endmodule

// ### bench/watchdog_timer_unit_monitor.sv
/*
 Port checker for the watchdog timer unit.
 Assumes one clock domain on mclk_i and an active high power-on reset.
*/
`timescale 1ns/1ps

module watchdog_timer_unit_monitor #(
    parameter int CNT_WIDTH = watchdog_timer_pkg::CNT_W
) (
    // Clock and resets.
    input wire logic                                  mclk_i,
    input wire logic                                  sys_rst_i,
    input wire logic                                  core_rst_i,
    // Register port.
    input wire logic [watchdog_timer_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [watchdog_timer_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic                                  reg_wr_i,
    input wire logic                                  reg_rd_i,
    input wire logic [watchdog_timer_pkg::DATA_W-1:0] reg_rdata_o,
    // Levels and events.
    input wire logic                                  lp_osc_i,
    input wire logic                                  debug_halt_i,
    input wire logic                                  periph_powerdown_i,
    input wire logic                                  timer_irq_o,
    input wire logic                                  wdt_core_reset_o
);
    import watchdog_timer_pkg::*;
    logic clr_wr;
    assign clr_wr = reg_wr_i && (reg_addr_i == CLEAR_ADDR);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    AST_RST_PULSE: assert property (wdt_core_reset_o |=> !wdt_core_reset_o)
        else $error("core reset request held longer than one cycle");
    AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data not zero outside a read answer");
    AST_RDATA_UPPER: assert property (reg_rd_i |=> reg_rdata_o[DATA_W-1:CNT_W] == '0)
        else $error("read data upper half not zero");
    AST_CLEAR_READ: assert property (reg_rd_i && reg_addr_i == CLEAR_ADDR |=> reg_rdata_o == '0)
        else $error("clear register read is not zero");
    AST_IRQ_STICKY: assert property (timer_irq_o && !clr_wr && !core_rst_i |=> timer_irq_o)
        else $error("interrupt dropped without a clear write");
    AST_IRQ_CLEAR: assert property (debug_halt_i [*4] ##0 clr_wr |=> !timer_irq_o)
        else $error("interrupt survived a clear write while frozen");
    AST_FREEZE: assert property (debug_halt_i [*4] |=> !wdt_core_reset_o && !$rose(timer_irq_o))
        else $error("timer event while the debugger holds the core");
    AST_RST_VALUES: assert property (disable iff (1'b0)
        sys_rst_i |=> reg_rdata_o == '0 && !timer_irq_o && !wdt_core_reset_o)
        else $error("outputs not quiet after power-on reset");

    cover property (wdt_core_reset_o);
    cover property ($rose(timer_irq_o));
    cover property (timer_irq_o && clr_wr);
endmodule

bind watchdog_timer_unit watchdog_timer_unit_monitor #(.CNT_WIDTH(CNT_WIDTH)) i_mon (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .core_rst_i(core_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .lp_osc_i(lp_osc_i), .debug_halt_i(debug_halt_i), .periph_powerdown_i(periph_powerdown_i),
    .timer_irq_o(timer_irq_o), .wdt_core_reset_o(wdt_core_reset_o));

// ### bench/watchdog_timer_unit_tb.sv
/*
 Self-checking bench for the watchdog timer unit.
 Assumes the monitor is bound from its own file; the oscillator pin is driven fast.
*/
`timescale 1ns/1ps

module watchdog_timer_unit_tb;
    import watchdog_timer_pkg::*;
    logic mclk_i, sys_rst_i, core_rst_i, reg_wr_i, reg_rd_i, lp_osc_i, debug_halt_i, periph_powerdown_i;
    logic timer_irq_o, wdt_core_reset_o;
    logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v;
    int failures, checks, cycles, rst_pulses;

    watchdog_timer_unit i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .core_rst_i(core_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .lp_osc_i(lp_osc_i), .debug_halt_i(debug_halt_i),
        .periph_powerdown_i(periph_powerdown_i), .timer_irq_o(timer_irq_o), .wdt_core_reset_o(wdt_core_reset_o));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // Far faster than the real oscillator so that timeouts fit a short run.
    initial begin
        lp_osc_i = 1'b0;
        forever #97 lp_osc_i = ~lp_osc_i;
    end
    always @(posedge mclk_i) begin
        if (wdt_core_reset_o === 1'b1) rst_pulses++;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic rng(input string what, input logic [31:0] lo, hi, got);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("[FAIL] %s expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        rng(what, exp, exp, got);
    endtask
    task automatic wr(input logic [31:0] a, d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task automatic rchk(input string what, input logic [31:0] a, exp);
        rd(a);
        chk(what, exp, v);
    endtask
    // The synchroniser needs a few cycles before a halt change takes hold.
    task automatic halt(input logic h);
        @(posedge mclk_i);
        debug_halt_i <= h;
        repeat (4) @(posedge mclk_i);
    endtask
    task automatic wait_rst(input int lim);
        int n, p;
        n = 0;
        p = rst_pulses;
        while (rst_pulses == p && n < lim) @(posedge mclk_i) #1 n++;
        chk("reset pulses", 1, rst_pulses - p);
    endtask
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (timer_irq_o !== 1'b1 && n < lim) @(posedge mclk_i) #1 n++;
        chk("irq raised", 1, timer_irq_o);
    endtask

    task automatic t_reset();
        rchk("reload", RELOAD_ADDR, 32'h0040);
        rchk("count", COUNT_ADDR, 32'h0040);
        rchk("control", CONTROL_ADDR, 32'h0000);
        rchk("clear", CLEAR_ADDR, 32'h0000);
        rchk("unmapped", 32'hffff0370, 32'h0000);
        wr(COUNT_ADDR, 32'h1234);
        rchk("count kept", COUNT_ADDR, 32'h0040);
    endtask
    task automatic t_modes();
        logic [15:0] ctl [7] = '{16'h004c, 16'h00cc, 16'h00c1, 16'h00c0, 16'h01c0, 16'h00c4, 16'h00c8};
        int wt [7] = '{300, 300, 300, 300, 300, 1000, 5200};
        logic [15:0] lo [7] = '{16'h40, 16'h40, 16'h40, 16'h30, 16'h4e, 16'h3c, 16'h3f};
        logic [15:0] hi [7] = '{16'h40, 16'h40, 16'h40, 16'h32, 16'h50, 16'h3e, 16'h3f};
        @(posedge mclk_i);
        periph_powerdown_i <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wr(CONTROL_ADDR, 32'h0);
            wr(RELOAD_ADDR, 32'h40);
            wr(CONTROL_ADDR, {16'h0, ctl[i]});
            repeat (wt[i]) @(posedge mclk_i);
            rd(COUNT_ADDR);
            rng("count after run", {16'h0, lo[i]}, {16'h0, hi[i]}, v);
        end
        @(posedge mclk_i);
        periph_powerdown_i <= 1'b0;
    endtask
    task automatic t_normal();
        wr(CONTROL_ADDR, 32'h0);
        wr(RELOAD_ADDR, 32'h3);
        wr(CONTROL_ADDR, 32'h00c0);
        wait_irq(200);
        halt(1'b1);
        repeat (10) @(posedge mclk_i);
        chk("irq held", 1, timer_irq_o);
        rchk("count reloaded", COUNT_ADDR, 32'h3);
        wr(CLEAR_ADDR, 32'h5a);
        #1 chk("irq cleared", 0, timer_irq_o);
        halt(1'b0);
    endtask
    // Free-running mode wraps through the opposite end point and still flags the event.
    task automatic t_free();
        logic [15:0] ld [2] = '{16'h0001, 16'hfffe};
        logic [15:0] ctl [2] = '{16'h0080, 16'h0180};
        logic [15:0] wrap [2] = '{16'hffff, 16'h0000};
        for (int i = 0; i < 2; i++) begin
            wr(CONTROL_ADDR, 32'h0);
            wr(RELOAD_ADDR, {16'h0, ld[i]});
            wr(CONTROL_ADDR, {16'h0, ctl[i]});
            wait_irq(200);
            halt(1'b1);
            rchk("free-running wrap", COUNT_ADDR, {16'h0, wrap[i]});
            wr(CLEAR_ADDR, 32'h0);
            #1 chk("free irq cleared", 0, timer_irq_o);
            halt(1'b0);
        end
    endtask
    task automatic t_watchdog();
        wr(CONTROL_ADDR, 32'h0);
        // Real software keeps timeouts above the erase floor; the fast bench oscillator scales this one down.
        wr(RELOAD_ADDR, 32'h2);
        wr(CONTROL_ADDR, 32'h0020);
        wait_rst(200);
        halt(1'b1);
        chk("no irq", 0, timer_irq_o);
        rchk("count at reload", COUNT_ADDR, 32'h2);
        wr(RELOAD_ADDR, 32'h5);
        rchk("reload locked", RELOAD_ADDR, 32'h2);
        wr(CONTROL_ADDR, 32'h0);
        rchk("control locked", CONTROL_ADDR, 32'h20);
        repeat (100) @(posedge mclk_i);
        rchk("count frozen", COUNT_ADDR, 32'h2);
        halt(1'b0);
        repeat (20) @(posedge mclk_i);
        halt(1'b1);
        rd(COUNT_ADDR);
        rng("count ran", 0, 1, v);
        wr(CLEAR_ADDR, 32'h0);
        rchk("count refreshed", COUNT_ADDR, 32'h2);
        @(posedge mclk_i);
        core_rst_i <= 1'b1;
        @(posedge mclk_i);
        core_rst_i <= 1'b0;
        rchk("mode kept", CONTROL_ADDR, 32'h20);
        rchk("count kept", COUNT_ADDR, 32'h2);
        halt(1'b0);
        wait_rst(200);
    endtask
    task automatic t_wdt_irq();
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rchk("control cleared", CONTROL_ADDR, 32'h0);
        wr(RELOAD_ADDR, 32'h1);
        wr(CONTROL_ADDR, 32'h0022);
        wait_irq(200);
        chk("no reset pulse", 0, rst_pulses - 2);
    endtask

    initial begin
        sys_rst_i = 1'b1;
        core_rst_i = 1'b0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        debug_halt_i = 1'b0;
        periph_powerdown_i = 1'b0;
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_modes();
        t_normal();
        t_free();
        t_watchdog();
        t_wdt_irq();
        finish_test();
    end
endmodule
